// ### core/aws_pkg.sv
package aws_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SEG_DEPTH = 64;
  localparam int RATE_W = 18;
  localparam int LEN_W = 16;
  localparam int MARK_W = 4;

  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_RATE = 8'h04;
  localparam logic [ADDR_W-1:0] REG_CMD = 8'h08;
  localparam logic [ADDR_W-1:0] REG_SEG_CFG = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_SEG_RATE = 8'h10;
  localparam logic [ADDR_W-1:0] REG_SEG_PUSH = 8'h14;
  localparam logic [ADDR_W-1:0] REG_ARB_LEN = 8'h18;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h1c;

  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MODE_BIT = 1;
  localparam int CTRL_CLK_LSB = 2;
  localparam int CTRL_TRIG_LSB = 4;
  localparam int CTRL_GATE_BIT = 6;
  localparam int CMD_CREATE_BIT = 0;
  localparam int CFG_MARK_LSB = 16;
  localparam int STAT_SEG_LSB = 8;
  localparam int STAT_ST_LSB = 16;
  localparam int STAT_ERR_BIT = 24;
  localparam int STAT_OVF_BIT = 25;

  localparam logic [RATE_W-1:0] RATE_MIN_KHZ = 18'h0000a;
  localparam logic [RATE_W-1:0] RATE_MAX_KHZ = 18'h3d090;
  localparam logic [RATE_W-1:0] RATE_RST_KHZ = 18'h186a0;
  localparam logic [LEN_W-1:0] REPS_RST = 16'h0001;
  localparam logic [LEN_W-1:0] ARB_LEN_RST = 16'h0001;

  typedef enum logic {MODE_ARB = 1'b0, MODE_SEQ = 1'b1} aws_mode_t;
  typedef enum logic [1:0] {
    CLK_CURRENT = 2'h0, CLK_HIGH = 2'h1, CLK_CUSTOM = 2'h2, CLK_BAD = 2'h3
  } aws_clk_t;
  typedef enum logic [1:0] {
    TRIG_CONT = 2'h0, TRIG_SINGLE = 2'h1, TRIG_STEP = 2'h2, TRIG_GATE = 2'h3
  } aws_trig_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1, ST_ARMED = 3'h2, ST_PLAY = 3'h4
  } aws_state_t;

endpackage : aws_pkg

// ### core/aws_rate_gen.sv
`timescale 1ns/1ps
module aws_rate_gen
  import aws_pkg::*;
#(
  parameter int RW = RATE_W,
  parameter logic [RATE_W-1:0] FULL = RATE_MAX_KHZ
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic run,
  input wire logic [RW-1:0] rate_khz,
  output logic tick
);

  typedef struct packed {
    logic [RW:0] acc;
    logic tick;
  } aws_rg_state_t;

  aws_rg_state_t q, n;
  logic [RW:0] sum;

  // One tick per sample, scaled so that the full-scale rate ticks every cycle.
  always_comb begin
    n = q;
    sum = q.acc + {1'b0, rate_khz};
    n.tick = 1'b0;
    if (!run) begin
      n.acc = '0;
    end else if (sum >= {1'b0, FULL}) begin
      n.acc = sum - {1'b0, FULL};
      n.tick = 1'b1;
    end else begin
      n.acc = sum;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign tick = q.tick;

endmodule : aws_rate_gen

// ### core/aws_sequencer.sv
`timescale 1ns/1ps
module aws_sequencer
  import aws_pkg::*;
#(
  parameter int NSEG = SEG_DEPTH
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic trig_pin,
  input wire logic gate_pin,
  output logic sample_strobe,
  output logic [LEN_W-1:0] sample_addr,
  output logic [$clog2(NSEG)-1:0] seg_index,
  output logic [MARK_W-1:0] marker_out,
  output logic [RATE_W-1:0] sample_rate_khz,
  output logic playing
);

  localparam int SEG_W = $clog2(NSEG);
  localparam int CNT_W = $clog2(NSEG + 1);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(NSEG);
  localparam logic [SEG_W-1:0] SEG_ONE = SEG_W'(1);
  localparam logic [LEN_W-1:0] LEN_ONE = 16'h0001;

  typedef struct packed {
    aws_state_t st;
    logic en;
    aws_mode_t mode;
    aws_clk_t clk_sel;
    aws_trig_t trig;
    logic gate_pol;
    logic [RATE_W-1:0] rate_custom;
    logic [LEN_W-1:0] cfg_reps;
    logic [MARK_W-1:0] cfg_mark;
    logic [RATE_W-1:0] cfg_rate;
    logic [LEN_W-1:0] arb_len;
    logic [NSEG-1:0][RATE_W-1:0] e_rate;
    logic [NSEG-1:0][LEN_W-1:0] e_reps;
    logic [NSEG-1:0][LEN_W-1:0] e_len;
    logic [NSEG-1:0][MARK_W-1:0] e_mark;
    logic [CNT_W-1:0] count;
    logic [RATE_W-1:0] max_rate;
    logic err;
    logic ovf;
    logic [2:0] trig_s;
    logic trig_lvl;
    logic [2:0] gate_s;
    logic gate_lvl;
    logic [SEG_W-1:0] seg;
    logic [LEN_W-1:0] rep;
    logic [LEN_W-1:0] pos;
    logic strobe_o;
    logic [LEN_W-1:0] addr_o;
    logic [SEG_W-1:0] seg_o;
    logic [MARK_W-1:0] mark_o;
    logic [RATE_W-1:0] rate_o;
    logic [DATA_W-1:0] rdata;
  } aws_seq_state_t;

  aws_seq_state_t q, n;
  logic tick, run, trig_evt, gate_on, has_data;
  logic last_smp, last_rep, last_seg, seg_end;
  logic [LEN_W-1:0] cur_len, cur_reps;
  logic [MARK_W-1:0] cur_mark;
  logic [CNT_W-1:0] n_segs;
  logic [RATE_W-1:0] wr_rate;
  aws_clk_t eff_clk;

  aws_rate_gen #(
    .RW(RATE_W),
    .FULL(RATE_MAX_KHZ)
  ) u_rate (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .run(run),
    .rate_khz(q.rate_o),
    .tick(tick)
  );

  function automatic logic rate_ok(input logic [DATA_W-1:0] v);
    rate_ok = (v[DATA_W-1:RATE_W] == '0) && (v[RATE_W-1:0] >= RATE_MIN_KHZ)
      && (v[RATE_W-1:0] <= RATE_MAX_KHZ);
  endfunction : rate_ok

  // Segment currently addressed; single-waveform mode is a one-entry list played once per pass.
  always_comb begin
    if (q.mode == MODE_ARB) begin
      cur_len = q.arb_len;
      cur_reps = LEN_ONE;
      cur_mark = '0;
      n_segs = CNT_ONE;
      has_data = 1'b1;
    end else begin
      cur_len = q.e_len[q.seg];
      cur_reps = q.e_reps[q.seg];
      cur_mark = q.e_mark[q.seg];
      n_segs = q.count;
      has_data = (q.count != '0);
    end
    gate_on = (q.gate_lvl == q.gate_pol);
    run = (q.st == ST_PLAY) && q.en && ((q.trig != TRIG_GATE) || gate_on);
    last_smp = (q.pos == cur_len - LEN_ONE);
    last_rep = (q.rep == cur_reps - LEN_ONE);
    last_seg = ((CNT_W'(q.seg) + CNT_ONE) >= n_segs);
    seg_end = tick && run && last_smp && last_rep;
    eff_clk = (q.mode == MODE_ARB) ? CLK_CUSTOM : q.clk_sel;
  end

  always_comb begin
    n = q;
    n.strobe_o = 1'b0;
    n.rdata = '0;
    trig_evt = 1'b0;
    wr_rate = reg_wdata[RATE_W-1:0];
    n.trig_s = {q.trig_s[1:0], trig_pin};
    n.gate_s = {q.gate_s[1:0], gate_pin};
    if (q.trig_s[1] == q.trig_s[2]) begin
      n.trig_lvl = q.trig_s[2];
      trig_evt = q.trig_s[2] & ~q.trig_lvl;
    end
    if (q.gate_s[1] == q.gate_s[2]) begin
      n.gate_lvl = q.gate_s[2];
    end

    if (reg_we) begin
      if (reg_addr == REG_CTRL) begin
        n.en = reg_wdata[CTRL_EN_BIT];
        n.mode = aws_mode_t'(reg_wdata[CTRL_MODE_BIT]);
        if (reg_wdata[CTRL_CLK_LSB+:2] != CLK_BAD) begin
          n.clk_sel = aws_clk_t'(reg_wdata[CTRL_CLK_LSB+:2]);
        end
        n.trig = aws_trig_t'(reg_wdata[CTRL_TRIG_LSB+:2]);
        n.gate_pol = reg_wdata[CTRL_GATE_BIT];
      end else if (reg_addr == REG_RATE) begin
        if (rate_ok(reg_wdata)) begin
          n.rate_custom = wr_rate;
        end
      end else if (reg_addr == REG_CMD) begin
        if (reg_wdata[CMD_CREATE_BIT] && q.mode == MODE_SEQ) begin
          n.count = '0;
          n.max_rate = '0;
          n.err = 1'b0;
          n.ovf = 1'b0;
        end
      end else if (reg_addr == REG_SEG_CFG) begin
        n.cfg_reps = reg_wdata[LEN_W-1:0];
        n.cfg_mark = reg_wdata[CFG_MARK_LSB+:MARK_W];
      end else if (reg_addr == REG_SEG_RATE) begin
        n.cfg_rate = wr_rate;
      end else if (reg_addr == REG_SEG_PUSH) begin
        if (q.count == CNT_FULL) begin
          n.ovf = 1'b1;
        end else if (q.cfg_reps == '0 || reg_wdata[LEN_W-1:0] == '0
                     || !rate_ok({{(DATA_W-RATE_W){1'b0}}, q.cfg_rate})) begin
          n.err = 1'b1;
        end else begin
          n.e_rate[q.count[SEG_W-1:0]] = q.cfg_rate;
          n.e_reps[q.count[SEG_W-1:0]] = q.cfg_reps;
          n.e_len[q.count[SEG_W-1:0]] = reg_wdata[LEN_W-1:0];
          n.e_mark[q.count[SEG_W-1:0]] = q.cfg_mark;
          n.count = q.count + CNT_ONE;
          if (q.cfg_rate > q.max_rate) begin
            n.max_rate = q.cfg_rate;
          end
        end
      end else if (reg_addr == REG_ARB_LEN) begin
        if (reg_wdata[LEN_W-1:0] != '0) begin
          n.arb_len = reg_wdata[LEN_W-1:0];
        end
      end
    end

    if (reg_re) begin
      if (reg_addr == REG_CTRL) begin
        n.rdata[CTRL_EN_BIT] = q.en;
        n.rdata[CTRL_MODE_BIT] = q.mode;
        n.rdata[CTRL_CLK_LSB+:2] = q.clk_sel;
        n.rdata[CTRL_TRIG_LSB+:2] = q.trig;
        n.rdata[CTRL_GATE_BIT] = q.gate_pol;
      end else if (reg_addr == REG_RATE) begin
        n.rdata[RATE_W-1:0] = q.rate_custom;
      end else if (reg_addr == REG_SEG_CFG) begin
        n.rdata[LEN_W-1:0] = q.cfg_reps;
        n.rdata[CFG_MARK_LSB+:MARK_W] = q.cfg_mark;
      end else if (reg_addr == REG_SEG_RATE) begin
        n.rdata[RATE_W-1:0] = q.cfg_rate;
      end else if (reg_addr == REG_ARB_LEN) begin
        n.rdata[LEN_W-1:0] = q.arb_len;
      end else if (reg_addr == REG_STATUS) begin
        n.rdata[CNT_W-1:0] = q.count;
        n.rdata[STAT_SEG_LSB+:SEG_W] = q.seg;
        n.rdata[STAT_ST_LSB+:3] = q.st;
        n.rdata[STAT_ERR_BIT] = q.err;
        n.rdata[STAT_OVF_BIT] = q.ovf;
      end
    end

    case (eff_clk)
      CLK_CURRENT: n.rate_o = q.e_rate[q.seg];
      CLK_HIGH: n.rate_o = q.max_rate;
      default: n.rate_o = q.rate_custom;
    endcase

    case (q.st)
      ST_IDLE: begin
        n.mark_o = '0;
        n.seg = '0;
        n.pos = '0;
        n.rep = '0;
        if (q.en) begin
          n.st = ST_ARMED;
        end
      end
      ST_ARMED: begin
        n.mark_o = '0;
        n.pos = '0;
        n.rep = '0;
        if (!q.en) begin
          n.st = ST_IDLE;
        end else if (has_data && ((q.trig == TRIG_GATE) ? gate_on : trig_evt)) begin
          n.st = ST_PLAY;
          if (CNT_W'(q.seg) >= n_segs) begin
            n.seg = '0;
          end
        end
      end
      ST_PLAY: begin
        // Trigger events are not looked at here, so a running pass cannot be cut short.
        if (!q.en) begin
          n.st = ST_IDLE;
          n.mark_o = '0;
        end else if (!has_data) begin
          n.st = ST_ARMED;
          n.seg = '0;
          n.mark_o = '0;
        end else if (tick && run) begin
          n.strobe_o = 1'b1;
          n.addr_o = q.pos;
          n.seg_o = q.seg;
          n.mark_o = cur_mark;
          n.pos = last_smp ? '0 : q.pos + LEN_ONE;
          if (last_smp) begin
            n.rep = last_rep ? '0 : q.rep + LEN_ONE;
          end
          if (seg_end) begin
            n.seg = last_seg ? '0 : q.seg + SEG_ONE;
            if (q.trig == TRIG_STEP || (q.trig == TRIG_SINGLE && last_seg)) begin
              n.st = ST_ARMED;
            end
          end
        end
      end
      default: n.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.clk_sel <= CLK_CUSTOM;
      q.rate_custom <= RATE_RST_KHZ;
      q.rate_o <= RATE_RST_KHZ;
      q.cfg_reps <= REPS_RST;
      q.cfg_rate <= RATE_RST_KHZ;
      q.arb_len <= ARB_LEN_RST;
    end else begin
      q <= n;
    end
  end

  assign reg_rdata = q.rdata;
  assign sample_strobe = q.strobe_o;
  assign sample_addr = q.addr_o;
  assign seg_index = q.seg_o;
  assign marker_out = q.mark_o;
  assign sample_rate_khz = q.rate_o;
  assign playing = (q.st == ST_PLAY);

  AST_DISABLE_STOPS: assert property (@(posedge sys_clk) disable iff (!resetn)
    !q.en |=> (q.st != ST_PLAY && q.mark_o == '0))
    else $error("Playback continued while disabled.");
  AST_ARB_CUSTOM: assert property (@(posedge sys_clk) disable iff (!resetn)
    q.mode == MODE_ARB |=> q.rate_o == $past(q.rate_custom))
    else $error("Single-waveform mode did not use the custom rate.");
  AST_CURRENT_RATE: assert property (@(posedge sys_clk) disable iff (!resetn)
    (q.mode == MODE_SEQ && q.clk_sel == CLK_CURRENT) |=> q.rate_o == $past(q.e_rate[q.seg]))
    else $error("Segment rate not followed.");
  AST_HIGH_RATE: assert property (@(posedge sys_clk) disable iff (!resetn)
    (q.mode == MODE_SEQ && q.clk_sel == CLK_HIGH) |=> q.rate_o == $past(q.max_rate))
    else $error("Highest segment rate not used.");
  AST_CUSTOM_RATE: assert property (@(posedge sys_clk) disable iff (!resetn)
    (q.mode == MODE_SEQ && q.clk_sel == CLK_CUSTOM) |=> q.rate_o == $past(q.rate_custom))
    else $error("Custom rate not used.");
  AST_RATE_RANGE: assert property (@(posedge sys_clk) disable iff (!resetn)
    q.rate_custom >= RATE_MIN_KHZ && q.rate_custom <= RATE_MAX_KHZ)
    else $error("Custom rate out of range.");
  AST_CREATE_EMPTY: assert property (@(posedge sys_clk) disable iff (!resetn)
    (reg_we && reg_addr == REG_CMD && reg_wdata[CMD_CREATE_BIT] && q.mode == MODE_SEQ)
    |=> (q.count == '0 && !q.ovf))
    else $error("Create request did not empty the list.");
  AST_LIST_FULL: assert property (@(posedge sys_clk) disable iff (!resetn)
    (reg_we && reg_addr == REG_SEG_PUSH && q.count == CNT_FULL) |=> (q.count == CNT_FULL && q.ovf))
    else $error("Load beyond the list limit was not rejected.");
  AST_SEG_ADVANCE: assert property (@(posedge sys_clk) disable iff (!resetn)
    (q.mode == MODE_SEQ && q.en && seg_end && !last_seg) |=> q.seg == $past(q.seg) + SEG_ONE)
    else $error("Sequence did not move to the next segment.");
  AST_MARKER_SET: assert property (@(posedge sys_clk) disable iff (!resetn)
    (q.en && q.mode == MODE_SEQ && has_data && tick && run) |=> (sample_strobe
      && marker_out == $past(cur_mark)))
    else $error("Sample did not carry its segment markers.");
  AST_TRIG_IGNORED: assert property (@(posedge sys_clk) disable iff (!resetn)
    (q.st == ST_PLAY && q.en && has_data && !seg_end && trig_evt) |=> q.st == ST_PLAY)
    else $error("Trigger disturbed a running playback.");
  AST_SINGLE_STOPS: assert property (@(posedge sys_clk) disable iff (!resetn)
    (q.trig == TRIG_SINGLE && q.en && has_data && seg_end && last_seg) |=> q.st == ST_ARMED)
    else $error("Single trigger mode did not stop after one pass.");

endmodule : aws_sequencer

// ### tb/aws_dac_model.sv
`timescale 1ns/1ps
module aws_dac_model
  import aws_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sample_strobe,
  input wire logic [LEN_W-1:0] sample_addr,
  input wire logic [5:0] seg_index,
  input wire logic [MARK_W-1:0] marker_out,
  input wire logic [RATE_W-1:0] sample_rate_khz
);
  // Each played sample is kept as segment, address, markers and rate for the bench.
  logic [43:0] q [$];
  always @(posedge sys_clk) begin
    if (sample_strobe === 1'b1) begin
      q.push_back({seg_index, sample_addr, marker_out, sample_rate_khz});
    end
  end
endmodule : aws_dac_model

// ### tb/arb_waveform_sequencer_tb_top.sv
`timescale 1ns/1ps
module arb_waveform_sequencer_tb_top
  import aws_pkg::*;
  ();
  localparam int NS = 3;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic trig_pin = 1'b0;
  logic gate_pin = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic sample_strobe;
  logic [LEN_W-1:0] sample_addr;
  logic [5:0] seg_index;
  logic [MARK_W-1:0] marker_out;
  logic [RATE_W-1:0] sample_rate_khz;
  logic playing;
  int miscompares = 0;
  int checks_done = 0;
  int tot = 0;
  int held = 0;
  logic [DATA_W-1:0] d;
  logic [DATA_W-1:0] rv [5];
  logic [RATE_W-1:0] cust;
  logic [RATE_W-1:0] max_rt;
  logic [RATE_W-1:0] seg_rt [NS];
  logic [MARK_W-1:0] seg_mk [NS];
  int seg_ln [NS];
  int seg_rp [NS];

  always #50 sys_clk = ~sys_clk;

  aws_sequencer dut (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .trig_pin(trig_pin), .gate_pin(gate_pin), .sample_strobe(sample_strobe),
    .sample_addr(sample_addr), .seg_index(seg_index), .marker_out(marker_out),
    .sample_rate_khz(sample_rate_khz), .playing(playing));
  aws_dac_model dac (.sys_clk(sys_clk), .sample_strobe(sample_strobe),
    .sample_addr(sample_addr), .seg_index(seg_index), .marker_out(marker_out),
    .sample_rate_khz(sample_rate_khz));

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [43:0] e, input logic [43:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge sys_clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_we <= 1'b0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge sys_clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_re <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic pulse();
    @(posedge sys_clk);
    trig_pin <= 1'b1;
    repeat (4) @(posedge sys_clk);
    trig_pin <= 1'b0;
  endtask : pulse

  // A second trigger in mid-play must not restart or extend the playback.
  task automatic play(input bit again);
    int n;
    n = 0;
    fork
      pulse();
    join_none
    while (playing !== 1'b1 && n < 50) begin
      tick(1);
      n++;
    end
    chk("play_start", 1, playing);
    if (again) begin
      repeat (6) @(posedge sys_clk);
      pulse();
    end
    while (playing === 1'b1 && n < 5000) begin
      tick(1);
      n++;
    end
    tick(8);
    chk("play_done", 0, playing);
  endtask : play

  function automatic logic [43:0] exp_smp(input int s, input int a, input int ck);
    logic [RATE_W-1:0] r;
    r = (ck == 0) ? seg_rt[s] : ((ck == 1) ? max_rt : cust);
    return {6'(s), 16'(a), seg_mk[s], r};
  endfunction : exp_smp

  task automatic cmp_seq(input int ck);
    int k;
    k = 0;
    for (int s = 0; s < NS; s++) begin
      for (int i = 0; i < seg_ln[s] * seg_rp[s]; i++) begin
        chk("sample", exp_smp(s, i % seg_ln[s], ck), dac.q[k]);
        k++;
      end
    end
    chk("samples", 44'(k), 44'(dac.q.size()));
  endtask : cmp_seq

  initial begin
    repeat (30000) @(posedge sys_clk);
    miscompares++;
    print_verdict();
  end

  initial begin
    void'($urandom(90344));
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(REG_STATUS);
    chk("status_rst", 32'h10000, d);
    chk("idle_out", 0, {playing, marker_out});
    chk("rate_rst", RATE_RST_KHZ, sample_rate_khz);
    rd(8'h40);
    chk("unmapped", 0, d);
    rv = '{32'h9, 32'h3d091, 32'ha, 32'h3d090, 32'h0};
    rv[4] = 32'(100000 + $urandom_range(100000));
    cust = RATE_RST_KHZ;
    foreach (rv[i]) begin
      wr(REG_RATE, rv[i]);
      if (rv[i] >= 10 && rv[i] <= 250000) cust = rv[i][RATE_W-1:0];
      rd(REG_RATE);
      chk("rate_reg", cust, d);
      chk("rate_out", cust, sample_rate_khz);
    end
    wr(REG_CTRL, 32'he);
    rd(REG_CTRL);
    chk("clk_code3", 32'ha, d);
    max_rt = '0;
    for (int s = 0; s < NS; s++) begin
      seg_ln[s] = (s == 0) ? 3 : 1 + $urandom_range(2);
      seg_rp[s] = (s == 0) ? 4 : 1 + $urandom_range(2);
      seg_mk[s] = (s == 0) ? 4'hf : ((s == 1) ? 4'h0 : 4'($urandom));
      seg_rt[s] = 18'(100000 + $urandom_range(100000));
      if (seg_rt[s] > max_rt) max_rt = seg_rt[s];
      tot += seg_ln[s] * seg_rp[s];
      wr(REG_SEG_CFG, {12'h0, seg_mk[s], 16'(seg_rp[s])});
      wr(REG_SEG_RATE, 32'(seg_rt[s]));
      wr(REG_SEG_PUSH, 32'(seg_ln[s]));
    end
    rd(REG_STATUS);
    chk("count", NS, d[6:0]);
    for (int ck = 0; ck < 3; ck++) begin
      dac.q.delete();
      wr(REG_CTRL, 32'h13 | 32'(ck << 2));
      play(1'b1);
      cmp_seq(ck);
    end
    wr(REG_CTRL, 32'h2b);
    for (int t = 0; t < NS; t++) begin
      dac.q.delete();
      play(1'b0);
      chk("step_count", seg_ln[t] * seg_rp[t], dac.q.size());
      chk("step_seg", t, dac.q[0][43:38]);
    end
    wr(REG_CTRL, 32'h0b);
    dac.q.delete();
    pulse();
    for (int n = 0; n < 2000 && dac.q.size() <= tot; n++) tick(1);
    chk("wrap", exp_smp(0, 0, 2), dac.q[tot]);
    wr(REG_CTRL, 32'h0a);
    tick(3);
    chk("disabled", 0, {playing, marker_out});
    dac.q.delete();
    wr(REG_CTRL, 32'h7b);
    tick(40);
    chk("gate_closed", 0, dac.q.size());
    @(posedge sys_clk);
    gate_pin <= 1'b1;
    for (int n = 0; n < 100 && dac.q.size() == 0; n++) tick(1);
    chk("gate_open", 1, playing);
    @(posedge sys_clk);
    gate_pin <= 1'b0;
    tick(8);
    held = dac.q.size();
    tick(20);
    chk("gate_pause", held, dac.q.size());
    chk("gate_hold", 1, playing);
    // Playback is stopped before the mode changes, so no stale position carries over.
    wr(REG_CTRL, 32'h7a);
    wr(REG_ARB_LEN, 32'h3);
    wr(REG_CTRL, 32'h11);
    wr(REG_CMD, 32'h1);
    rd(REG_STATUS);
    chk("create_arb", NS, d[6:0]);
    dac.q.delete();
    play(1'b0);
    for (int a = 0; a < 3; a++) chk("arb", {6'h0, 16'(a), 4'h0, cust}, dac.q[a]);
    chk("arb_count", 3, dac.q.size());
    wr(REG_CTRL, 32'h2);
    wr(REG_CMD, 32'h1);
    rd(REG_STATUS);
    chk("create", 0, d[6:0]);
    for (int i = 0; i <= SEG_DEPTH; i++) wr(REG_SEG_PUSH, 32'h1);
    rd(REG_STATUS);
    chk("full", {1'b1, 7'(SEG_DEPTH)}, {d[25], d[6:0]});
    wr(REG_CMD, 32'h1);
    wr(REG_SEG_CFG, 32'h0);
    wr(REG_SEG_PUSH, 32'h1);
    wr(REG_SEG_CFG, 32'hffff);
    wr(REG_SEG_PUSH, 32'h1);
    rd(REG_STATUS);
    chk("reps_limits", {1'b1, 7'h1}, {d[24], d[6:0]});
    print_verdict();
  end
endmodule : arb_waveform_sequencer_tb_top
